// ===== sdw_serial_dac_write.sv
`timescale 1ns/1ps
`default_nettype none
module sdw_serial_dac_write (
   // System side
   input  wire logic                        clk_i,
   input  wire logic                        sys_rst_i,
   // Serial link
   input  wire logic                        sclk_i,
   input  wire logic                        sync_n_i,
   input  wire logic                        din_i,
   // Converter control
   output logic [sdw_pkg::CODE_W-1:0]       dac_code_o,
   output logic [sdw_pkg::MODE_W-1:0]       power_mode_o,
   output logic                             normal_mode_o,
   output logic                             pd_1k_o,
   output logic                             pd_100k_o,
   output logic                             pd_hiz_o,
   output logic                             update_o
);

   // One-hot width follows the mode field
   localparam int unsigned DEC_W = 2 ** sdw_pkg::MODE_W;

   ////////////////////////////////////////////////////////////////////////
   // Link domain, cleared by frame select high
   //
   // The serial clock is the only clock at the pins and may stop between
   // frames, so nothing in this domain may wait for a further edge to
   // finish its work: the sixteenth fall both shifts and hands over.

   typedef struct packed {
      logic [sdw_pkg::CNT_W-1:0]  cnt;
      logic [sdw_pkg::WORD_W-1:0] shift;
   } sdw_link_t;

   typedef struct packed {
      logic [sdw_pkg::WORD_W-1:0] word;
      logic                       tgl;
   } sdw_hold_t;

   typedef struct packed {
      logic                       link_rst;
      logic                       s1;
      logic                       s2;
      logic                       s3;
      logic                       seen;
      logic [sdw_pkg::CODE_W-1:0] code;
      sdw_pkg::sdw_mode_t         mode;
      logic                       upd;
      logic [DEC_W-1:0]           dec;
   } sdw_sys_t;

   sdw_link_t link_ff;
   sdw_link_t nxt_link;
   sdw_hold_t hold_ff;
   sdw_hold_t nxt_hold;
   sdw_sys_t  sys_ff;
   sdw_sys_t  nxt_sys;

   always_comb begin
      nxt_link = link_ff;
      // Extra edges after the sixteenth are ignored
      if (link_ff.cnt != sdw_pkg::CNT_FULL) begin
         nxt_link.cnt = link_ff.cnt + 5'h01;
         nxt_link.shift = {link_ff.shift[sdw_pkg::WORD_W-2:0], din_i};
      end
   end

   // Frame select high acts as asynchronous clear: aborts and rearms
   always_ff @(negedge sclk_i or posedge sync_n_i) begin
      if (sync_n_i) begin
         link_ff <= '0;
      end else begin
         link_ff <= nxt_link;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Completed word, survives the frame end

   always_comb begin
      nxt_hold = hold_ff;
      if (link_ff.cnt == sdw_pkg::LAST_BIT) begin
         nxt_hold.word = {link_ff.shift[sdw_pkg::WORD_W-2:0], din_i};
         nxt_hold.tgl = ~hold_ff.tgl;
      end
   end

   // Reset comes from the system domain since the link clock may idle
   always_ff @(negedge sclk_i or posedge sys_ff.link_rst) begin
      if (sys_ff.link_rst) begin
         hold_ff <= '0;
      end else begin
         hold_ff <= nxt_hold;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // System domain: toggle crossing and output registers
   //
   // Only the toggle crosses through flip-flops. The holding word is
   // read after the toggle has settled; it is single-buffered, so frames
   // closer than about four system cycles may overwrite a word unseen.

   // True when the loaded mode equals the one asked for
   function automatic logic mode_is(input sdw_pkg::sdw_mode_t m,
                                    input sdw_pkg::sdw_mode_t ref_m);
      mode_is = (m == ref_m);
   endfunction

   // One bit per output load option
   function automatic logic [DEC_W-1:0] mode_dec(
      input sdw_pkg::sdw_mode_t m
   );
      mode_dec = '0;
      mode_dec[0] = mode_is(m, sdw_pkg::SDW_MODE_NORMAL);
      mode_dec[1] = mode_is(m, sdw_pkg::SDW_MODE_PD_1K);
      mode_dec[2] = mode_is(m, sdw_pkg::SDW_MODE_PD_100K);
      mode_dec[3] = mode_is(m, sdw_pkg::SDW_MODE_PD_HIZ);
   endfunction

   always_comb begin
      nxt_sys = sys_ff;

      // Registered reset copy also clears the link-side holding word
      nxt_sys.link_rst = sys_rst_i;

      // Three-stage synchroniser on the link toggle
      nxt_sys.s1 = hold_ff.tgl;
      nxt_sys.s2 = sys_ff.s1;
      nxt_sys.s3 = sys_ff.s2;

      nxt_sys.upd = 1'b0;

      // A change counts once stages two and three agree
      // Word is stable for many link edges after the toggle moves
      if ((sys_ff.s2 == sys_ff.s3) && (sys_ff.s3 != sys_ff.seen)) begin
         nxt_sys.seen = sys_ff.s3;
         nxt_sys.code = hold_ff.word[sdw_pkg::CODE_HI:sdw_pkg::CODE_LO];
         nxt_sys.mode = sdw_pkg::sdw_mode_t'(
            hold_ff.word[sdw_pkg::MODE_HI:sdw_pkg::MODE_LO]);
         nxt_sys.upd = 1'b1;
      end

      if (sys_rst_i) begin
         nxt_sys = '0;
         nxt_sys.link_rst = 1'b1;
         nxt_sys.code = sdw_pkg::CODE_RST;
         nxt_sys.mode = sdw_pkg::MODE_RST;
      end

      // Decode is registered with the mode so both move together
      nxt_sys.dec = mode_dec(nxt_sys.mode);
   end

   always_ff @(posedge clk_i) begin
      sys_ff <= nxt_sys;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from the system register

   assign dac_code_o    = sys_ff.code;
   assign power_mode_o  = sys_ff.mode;
   assign normal_mode_o = sys_ff.dec[0];
   assign pd_1k_o       = sys_ff.dec[1];
   assign pd_100k_o     = sys_ff.dec[2];
   assign pd_hiz_o      = sys_ff.dec[3];
   assign update_o      = sys_ff.upd;

endmodule // sdw_serial_dac_write
`default_nettype wire

// ===== sdw_pkg.sv
// Behaviour
// - Sixteen-bit input shift register fed from data
// - Data sampled on serial clock falling edges
// - Low frame select enables shifting; host holds
// - Sixteenth edge loads code and power mode
// - Early frame select rise discards partial write
// - Code is unsigned straight binary 0..4095
// - Word: two ignored, two mode, twelve code
// - Mode 00 normal, 01/10/11 power-down loads
// - Reset clears code until valid frame
`default_nettype none
package sdw_pkg;
   localparam int unsigned WORD_W     = 16;
   localparam int unsigned CODE_W     = 12;
   localparam int unsigned MODE_W     = 2;
   localparam int unsigned CNT_W      = 5;
   localparam int unsigned MODE_HI    = 13;
   localparam int unsigned MODE_LO    = 12;
   localparam int unsigned CODE_HI    = 11;
   localparam int unsigned CODE_LO    = 0;
   localparam logic [CNT_W-1:0] LAST_BIT = 5'h0f;
   localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
   localparam logic [CODE_W-1:0] CODE_RST = 12'h000;
   localparam logic [CODE_W-1:0] CODE_MAX = 12'hfff;

   typedef enum logic [MODE_W-1:0] {
      SDW_MODE_NORMAL = 2'b00,
      SDW_MODE_PD_1K  = 2'b01,
      SDW_MODE_PD_100K = 2'b10,
      SDW_MODE_PD_HIZ = 2'b11
   } sdw_mode_t;

   localparam sdw_mode_t MODE_RST = SDW_MODE_NORMAL;
endpackage
`default_nettype wire

// ===== sdw_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sdw_checker (
   // Clock and reset
   input wire logic                       clk_i,
   input wire logic                       sys_rst_i,
   // Watched outputs
   input wire logic [sdw_pkg::CODE_W-1:0] dac_code_o,
   input wire logic [sdw_pkg::MODE_W-1:0] power_mode_o,
   input wire logic                       normal_mode_o,
   input wire logic                       pd_1k_o,
   input wire logic                       pd_100k_o,
   input wire logic                       pd_hiz_o,
   input wire logic                       update_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // Update pulse ends after one cycle
   sequence s_upd_end;
      ##1 !update_o;
   endsequence
   a_update_pulse: assert property (update_o |-> s_upd_end)
      else $error("long update");
   a_onehot_dec: assert property ($onehot({pd_hiz_o, pd_100k_o,
      pd_1k_o, normal_mode_o}))
      else $error("decode not one-hot");
   a_hiz_dec: assert property ((power_mode_o == 2'h3) == pd_hiz_o)
      else $error("bad hiz decode");
   a_code_cause: assert property ($changed(dac_code_o) |-> update_o)
      else $error("code moved");
   a_mode_cause: assert property ($changed(power_mode_o) |-> update_o)
      else $error("mode moved");
   a_rst_clear: assert property ($fell(sys_rst_i) |-> !dac_code_o)
      else $error("no clear");
   a_decode: assert property (normal_mode_o == !power_mode_o)
      else $error("bad decode");
endmodule // sdw_checker
bind sdw_serial_dac_write sdw_checker u_chk (.*);
`default_nettype wire

// ===== sdw_host.sv
`timescale 1ns/1ps
`default_nettype none
module sdw_host (output logic sclk_o, sync_n_o, din_o);
   initial {sclk_o, sync_n_o, din_o} = 3'h2;
   task automatic send(input logic [15:0] w, input int n);
      #41.3 sync_n_o = 1'h0;
      for (int i = 15; i > 15 - n; i--) begin
         din_o = w[i];
         #1 sclk_o = 1'h1;
         #3 sclk_o = 1'h0;
         #2 din_o = ~w[i];
      end
      #4 sync_n_o = 1'h1;
   endtask
endmodule // sdw_host
`default_nettype wire

// ===== sdw_serial_dac_write_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sdw_serial_dac_write_bench;
   logic clk_i = 1'h0, sys_rst_i = 1'h1;
   wire sclk_i, sync_n_i, din_i, update_o, normal_mode_o;
   wire pd_1k_o, pd_100k_o, pd_hiz_o;
   wire [11:0] dac_code_o;
   wire [1:0] power_mode_o;
   int fails = 0, check_count = 0;
   sdw_host host (.sclk_o(sclk_i), .sync_n_o(sync_n_i), .din_o(din_i));
   sdw_serial_dac_write dut (
      .clk_i         (clk_i),
      .sys_rst_i     (sys_rst_i),
      .sclk_i        (sclk_i),
      .sync_n_i      (sync_n_i),
      .din_i         (din_i),
      .dac_code_o    (dac_code_o),
      .power_mode_o  (power_mode_o),
      .normal_mode_o (normal_mode_o),
      .pd_1k_o       (pd_1k_o),
      .pd_100k_o     (pd_100k_o),
      .pd_hiz_o      (pd_hiz_o),
      .update_o      (update_o)
   );
   initial forever #5 clk_i = ~clk_i;
   task automatic chk(input logic ok, input string m);
      check_count++;
      if (ok !== 1'h1) $display("mismatch %0t %s", $time, m);
      fails += int'(ok !== 1'h1);
   endtask
   task automatic frame(input logic [1:0] m, input logic [11:0] c);
      host.send({2'h3, m, c}, 16);
      for (int n = 0; n < 30 && update_o !== 1'h1; n++) @(negedge clk_i);
      chk(update_o && power_mode_o === m && dac_code_o === c, "load");
      chk({pd_hiz_o, pd_100k_o, pd_1k_o, normal_mode_o} === 4'h1 << m,
          "decode");
      @(negedge clk_i);
      chk(update_o === 1'h0, "pulse");
   endtask
   task automatic reset_start;
      repeat (4) @(negedge clk_i);
      chk(dac_code_o === 12'h000 && normal_mode_o === 1'h1, "reset");
      sys_rst_i = 1'h0;
   endtask
   task automatic reset_mid;
      @(negedge clk_i);
      sys_rst_i = 1'h1;
      repeat (4) @(negedge clk_i);
      chk(dac_code_o === 12'h000 && power_mode_o === 2'h0, "rst");
      chk(normal_mode_o === 1'h1 && update_o === 1'h0, "rst dec");
      sys_rst_i = 1'h0;
      repeat (2) @(negedge clk_i);
      chk(dac_code_o === 12'h000 && update_o === 1'h0, "rst hold");
   endtask
   task automatic abort_frame;
      logic hit;
      hit = 1'h0;
      host.send(16'h3abc, 8);
      repeat (20) begin
         @(negedge clk_i);
         hit = hit | (update_o !== 1'h0);
      end
      chk(dac_code_o === 12'h1ff && power_mode_o === 2'h3, "abort");
      chk(hit === 1'h0, "abort update");
   endtask
   task automatic wrap_up;
      $display("%0d checks %0d fails", check_count, fails);
      if (fails == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      reset_start();
      for (int k = 1; k < 4; k++) frame(2'(k), 12'hfff >> k);
      abort_frame();
      frame(2'h0, 12'hfff);
      reset_mid();
      frame(2'h2, 12'h5a5);
      wrap_up();
   end
   initial begin
      #20000 fails++;
      wrap_up();
   end
endmodule // sdw_serial_dac_write_bench
`default_nettype wire
